/* design/pdcr_map.vh */
// Register offsets, field positions and reset values of the peripheral DMA channel registers
`ifndef PDCR_MAP_VH
`define PDCR_MAP_VH
`define PDCR_OFF_RX_ADDR 12'h100
`define PDCR_OFF_RX_COUNT 12'h104
`define PDCR_OFF_TX_ADDR 12'h108
`define PDCR_OFF_TX_COUNT 12'h10C
`define PDCR_OFF_RX_NEXT_ADDR 12'h110
`define PDCR_OFF_RX_NEXT_COUNT 12'h114
`define PDCR_OFF_TX_NEXT_ADDR 12'h118
`define PDCR_OFF_TX_NEXT_COUNT 12'h11C
`define PDCR_OFF_CONTROL 12'h120
`define PDCR_OFF_STATE 12'h124
`define PDCR_BIT_RX_EN 0
`define PDCR_BIT_RX_DIS 1
`define PDCR_BIT_TX_EN 8
`define PDCR_BIT_TX_DIS 9
`define PDCR_RESET_ADDR 32'h0000_0000
`define PDCR_RESET_COUNT 16'h0000
`endif

/* design/pdcr_regs.v */
// Peripheral DMA channel pair: APB registers, pointer and counter management, request flags
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
`include "pdcr_map.vh"

// Operation
// - Ten registers at 0x100 to 0x124, all reset to zero.
// - Current receive address register holds full 32-bit buffer address.
// - Receive count in bits 15:0; zero stops receive transfers.
// - Receive moves data when count is 1 to 65535 and enabled.
// - Current transmit address register holds full 32-bit buffer address.
// - Transmit count in 16-bit field; zero stops transmit transfers.
// - Transmit moves data when count is 1 to 65535 and enabled.
// - Half duplex: receive and transmit current address read the same.
// - Half duplex: receive and transmit current count read the same.
// - Next receive address register stores 32-bit following buffer address.
// - Next receive count stores 16-bit size; upper bits reserved.
// - Next transmit address register stores 32-bit following buffer address.
// - Next transmit count register stores 16-bit following buffer size.
// - Half duplex: next address and count shared between directions.
// - Control bit 0 enables receive unless bit 1 also set; zeros ignored.
// - Control bit 1 disables receive requests.
// - Control bit 8 enables transmit requests.
// - Control bit 9 disables transmit requests.
// - Half duplex: receive enable also disables transmit.
// - Half duplex: transmit enable takes effect only without receive enable.
// - Half duplex: receive disable also disables transmit.
// - Half duplex: transmit disable also disables receive.
// - Current count zero reloads from nonzero next, clearing next; else stop.
// - Address advances by 1, 2 or 4 bytes per item.
// - Status bit 0 shows receive enabled, bit 8 transmit enabled.
// - End flag at current zero; full/empty flag at current and next zero.
module pdcr_regs #(
   parameter HALF_DUPLEX = 0
)
(
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire [1:0] xfer_size,
   input wire rx_item_done,
   input wire tx_item_done,
   output reg rx_request_active,
   output reg tx_request_active,
   output reg [31:0] rx_mem_addr,
   output reg [31:0] tx_mem_addr,
   output reg rx_end_flag,
   output reg rx_buffer_full_flag,
   output reg tx_end_flag,
   output reg tx_buffer_empty_flag
);

   reg [31:0] rx_addr_field;
   reg [15:0] rx_count_field;
   reg [31:0] tx_addr_field;
   reg [15:0] tx_count_field;
   reg [31:0] rx_following_addr_field;
   reg [15:0] rx_following_count_field;
   reg [31:0] tx_following_addr_field;
   reg [15:0] tx_following_count_field;
   reg rx_request_enable_state;
   reg tx_request_enable_state;
   reg next_rx_en;
   reg next_tx_en;
   reg [31:0] read_mux;
   reg read_ok;

   wire access = psel & penable & pready;
   wire wr = access & pwrite;
   wire wr_rx_addr = wr & (paddr == `PDCR_OFF_RX_ADDR);
   wire wr_rx_cnt = wr & (paddr == `PDCR_OFF_RX_COUNT);
   wire wr_tx_addr = wr & (paddr == `PDCR_OFF_TX_ADDR);
   wire wr_tx_cnt = wr & (paddr == `PDCR_OFF_TX_COUNT);
   wire wr_rxn_addr = wr & (paddr == `PDCR_OFF_RX_NEXT_ADDR);
   wire wr_rxn_cnt = wr & (paddr == `PDCR_OFF_RX_NEXT_COUNT);
   wire wr_txn_addr = wr & (paddr == `PDCR_OFF_TX_NEXT_ADDR);
   wire wr_txn_cnt = wr & (paddr == `PDCR_OFF_TX_NEXT_COUNT);
   wire wr_ctrl = wr & (paddr == `PDCR_OFF_CONTROL);
   wire hd = (HALF_DUPLEX != 0);

   // Byte step for one item
   function [31:0] step_of;
      input [1:0] size;
      begin
         case (size)
            2'b00: step_of = 32'h0000_0001;
            2'b01: step_of = 32'h0000_0002;
            default: step_of = 32'h0000_0004;
         endcase
      end
   endfunction

   // Count that still has items to move
   function live;
      input [15:0] cnt;
      begin
         live = (cnt != 16'h0000);
      end
   endfunction

   // Items only count when the channel is enabled and has work
   wire rx_go = rx_request_enable_state & live(rx_count_field);
   wire tx_go = tx_request_enable_state & live(tx_count_field);
   wire rx_step = rx_go & rx_item_done;
   // In half duplex the receive item has the channel when both strobe
   wire tx_step = tx_go & tx_item_done & ~(hd & rx_step);
   wire rx_last = rx_step & (rx_count_field == 16'h0001);
   wire tx_last = tx_step & (tx_count_field == 16'h0001);

   // Enable and disable bits of the control register
   always @*
   begin
      next_rx_en = rx_request_enable_state;
      next_tx_en = tx_request_enable_state;
      if (wr_ctrl)
      begin
         if (pwdata[`PDCR_BIT_RX_EN] & ~pwdata[`PDCR_BIT_RX_DIS])
         begin
            next_rx_en = 1'b1;
            // A shared channel serves one direction at a time
            if (hd)
            begin
               next_tx_en = 1'b0;
            end
         end
         if (pwdata[`PDCR_BIT_TX_EN] & ~pwdata[`PDCR_BIT_TX_DIS] &
            ~(hd & pwdata[`PDCR_BIT_RX_EN]))
         begin
            next_tx_en = 1'b1;
         end
         // Disables come last so that they win over enables
         if (pwdata[`PDCR_BIT_RX_DIS])
         begin
            next_rx_en = 1'b0;
            if (hd)
            begin
               next_tx_en = 1'b0;
            end
         end
         if (pwdata[`PDCR_BIT_TX_DIS])
         begin
            next_tx_en = 1'b0;
            if (hd)
            begin
               next_rx_en = 1'b0;
            end
         end
      end
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rx_request_enable_state <= 1'b0;
         tx_request_enable_state <= 1'b0;
      end
      else
      begin
         rx_request_enable_state <= next_rx_en;
         tx_request_enable_state <= next_tx_en;
      end
   end

   // Pointers and counters; in half duplex both directions write both stores
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rx_addr_field <= `PDCR_RESET_ADDR;
         rx_count_field <= `PDCR_RESET_COUNT;
         tx_addr_field <= `PDCR_RESET_ADDR;
         tx_count_field <= `PDCR_RESET_COUNT;
         rx_following_addr_field <= `PDCR_RESET_ADDR;
         rx_following_count_field <= `PDCR_RESET_COUNT;
         tx_following_addr_field <= `PDCR_RESET_ADDR;
         tx_following_count_field <= `PDCR_RESET_COUNT;
      end
      else
      begin
         // Channel side: advance, count down, reload from the following buffer
         if (rx_step | (hd & tx_step))
         begin
            rx_addr_field <= rx_addr_field + step_of(xfer_size);
            rx_count_field <= rx_count_field - 16'h0001;
            if ((rx_last | (hd & tx_last)) && rx_following_count_field != 16'h0000)
            begin
               rx_addr_field <= rx_following_addr_field;
               rx_count_field <= rx_following_count_field;
               rx_following_addr_field <= `PDCR_RESET_ADDR;
               rx_following_count_field <= `PDCR_RESET_COUNT;
            end
         end

         // A shared channel moves both stores together so they never part
         if (tx_step | (hd & rx_step))
         begin
            tx_addr_field <= tx_addr_field + step_of(xfer_size);
            tx_count_field <= tx_count_field - 16'h0001;
            if ((tx_last | (hd & rx_last)) && tx_following_count_field != 16'h0000)
            begin
               tx_addr_field <= tx_following_addr_field;
               tx_count_field <= tx_following_count_field;
               tx_following_addr_field <= `PDCR_RESET_ADDR;
               tx_following_count_field <= `PDCR_RESET_COUNT;
            end
         end

         // Software writes win over a concurrent channel update
         if (wr_rx_addr | (hd & wr_tx_addr))
         begin
            rx_addr_field <= pwdata;
         end
         if (wr_tx_addr | (hd & wr_rx_addr))
         begin
            tx_addr_field <= pwdata;
         end
         if (wr_rx_cnt | (hd & wr_tx_cnt))
         begin
            rx_count_field <= pwdata[15:0];
         end
         if (wr_tx_cnt | (hd & wr_rx_cnt))
         begin
            tx_count_field <= pwdata[15:0];
         end
         if (wr_rxn_addr | (hd & wr_txn_addr))
         begin
            rx_following_addr_field <= pwdata;
         end
         if (wr_txn_addr | (hd & wr_rxn_addr))
         begin
            tx_following_addr_field <= pwdata;
         end
         if (wr_rxn_cnt | (hd & wr_txn_cnt))
         begin
            rx_following_count_field <= pwdata[15:0];
         end
         if (wr_txn_cnt | (hd & wr_rxn_cnt))
         begin
            tx_following_count_field <= pwdata[15:0];
         end
      end
   end

   // Flags to the peripheral; set wins over clear by a nonzero count write
   wire rx_clr = (wr_rx_cnt | wr_rxn_cnt | (hd & (wr_tx_cnt | wr_txn_cnt))) &
      (pwdata[15:0] != 16'h0000);
   wire tx_clr = (wr_tx_cnt | wr_txn_cnt | (hd & (wr_rx_cnt | wr_rxn_cnt))) &
      (pwdata[15:0] != 16'h0000);

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rx_end_flag <= 1'b0;
         rx_buffer_full_flag <= 1'b0;
         tx_end_flag <= 1'b0;
         tx_buffer_empty_flag <= 1'b0;
      end
      else
      begin
         // Receive flags: a set wins over a clearing write in the same cycle
         if (rx_last)
         begin
            rx_end_flag <= 1'b1;
         end
         else if (rx_clr)
         begin
            rx_end_flag <= 1'b0;
         end
         if (rx_last && rx_following_count_field == 16'h0000)
         begin
            rx_buffer_full_flag <= 1'b1;
         end
         else if (rx_clr)
         begin
            rx_buffer_full_flag <= 1'b0;
         end

         // Transmit flags, same priority
         if (tx_last)
         begin
            tx_end_flag <= 1'b1;
         end
         else if (tx_clr)
         begin
            tx_end_flag <= 1'b0;
         end
         if (tx_last && tx_following_count_field == 16'h0000)
         begin
            tx_buffer_empty_flag <= 1'b1;
         end
         else if (tx_clr)
         begin
            tx_buffer_empty_flag <= 1'b0;
         end
      end
   end

   // Request and address outputs, registered from the current state
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rx_request_active <= 1'b0;
         tx_request_active <= 1'b0;
         rx_mem_addr <= `PDCR_RESET_ADDR;
         tx_mem_addr <= `PDCR_RESET_ADDR;
      end
      else
      begin
         // A stepping item drops the request for a cycle while the count moves
         rx_request_active <= rx_go & ~rx_step;
         tx_request_active <= tx_go & ~tx_step;
         rx_mem_addr <= rx_addr_field;
         tx_mem_addr <= tx_addr_field;
      end
   end

   // Read decode; control register reads as zero
   always @*
   begin
      read_mux = 32'h0000_0000;
      read_ok = 1'b1;
      case (paddr)
         `PDCR_OFF_RX_ADDR: read_mux = rx_addr_field;
         `PDCR_OFF_RX_COUNT: read_mux = {16'h0000, rx_count_field};
         `PDCR_OFF_TX_ADDR: read_mux = tx_addr_field;
         `PDCR_OFF_TX_COUNT: read_mux = {16'h0000, tx_count_field};
         `PDCR_OFF_RX_NEXT_ADDR: read_mux = rx_following_addr_field;
         `PDCR_OFF_RX_NEXT_COUNT: read_mux = {16'h0000, rx_following_count_field};
         `PDCR_OFF_TX_NEXT_ADDR: read_mux = tx_following_addr_field;
         `PDCR_OFF_TX_NEXT_COUNT: read_mux = {16'h0000, tx_following_count_field};
         `PDCR_OFF_CONTROL: read_mux = 32'h0000_0000;
         `PDCR_OFF_STATE:
         begin
            read_mux[`PDCR_BIT_RX_EN] = rx_request_enable_state;
            read_mux[`PDCR_BIT_TX_EN] = tx_request_enable_state;
         end
         default: read_ok = 1'b0;
      endcase
   end

   // APB slave: one wait state, answer on the second access cycle
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
      else
      begin
         // pready falls after one cycle, so a held request is answered every second cycle
         pready <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & ~read_ok;
         // prdata holds the last read answer
         if (psel & penable & ~pready & ~pwrite)
         begin
            prdata <= read_mux;
         end
      end
   end

endmodule // pdcr_regs

/* tb/pdcr_periph_model.sv */
// Serial peripheral model: strobes items while a channel requests
`timescale 1ns/1ps
module pdcr_periph_model
(
   input wire pclk,
   input wire presetn,
   input wire rx_request_active,
   input wire tx_request_active,
   output reg rx_item_done,
   output reg tx_item_done
);
   reg [7:0] lfsr;
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         lfsr <= 8'h5a;
         rx_item_done <= 1'b0;
         tx_item_done <= 1'b0;
      end
      else
      begin
         lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
         // Random stalls, sometimes back to back items
         rx_item_done <= rx_request_active && lfsr[0];
         tx_item_done <= tx_request_active && lfsr[1];
      end
   end
endmodule // pdcr_periph_model

/* tb/pdcr_regs_asserts.sv */
// Checker for the peripheral DMA channel register block
`timescale 1ns/1ps
module pdcr_asserts #(
   parameter HALF_DUPLEX = 0
)
(
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire [1:0] xfer_size,
   input wire rx_item_done,
   input wire tx_item_done,
   input wire rx_request_active,
   input wire tx_request_active,
   input wire [31:0] rx_mem_addr,
   input wire [31:0] tx_mem_addr,
   input wire rx_end_flag,
   input wire rx_buffer_full_flag,
   input wire tx_end_flag,
   input wire tx_buffer_empty_flag
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire wr_done = pready && pwrite;
   a_ready_time: assert property ($rose(penable) && psel |=> pready)
      else $error("late bus answer");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("long bus answer");
   a_map_ok: assert property (pready && paddr >= 12'h100 && paddr <= 12'h124
      && paddr[1:0] == 2'b00 |-> !pslverr) else $error("mapped place refused");
   a_full_end: assert property (rx_buffer_full_flag |-> rx_end_flag)
      else $error("full without end");
   a_empty_end: assert property (tx_buffer_empty_flag |-> tx_end_flag)
      else $error("empty without end");
   a_full_idle: assert property (rx_buffer_full_flag |-> !rx_request_active)
      else $error("rx requests with no buffer");
   a_rx_off: assert property (wr_done && paddr == 12'h120 && pwdata[1]
      |-> ##2 !rx_request_active) else $error("rx still requests");
   a_tx_off: assert property (wr_done && paddr == 12'h120 && pwdata[9]
      |-> ##2 !tx_request_active) else $error("tx still requests");
   a_rx_addr_cause: assert property ($changed(rx_mem_addr)
      |-> $past(rx_item_done, 2) || (HALF_DUPLEX != 0 && $past(tx_item_done, 2))
      || $past(wr_done, 2)) else $error("rx address moved");
   a_tx_addr_cause: assert property ($changed(tx_mem_addr)
      |-> $past(tx_item_done, 2) || (HALF_DUPLEX != 0 && $past(rx_item_done, 2))
      || $past(wr_done, 2)) else $error("tx address moved");
   cover property (rx_buffer_full_flag);
   cover property (tx_buffer_empty_flag);
   cover property (pready && pslverr);
endmodule // pdcr_asserts

bind pdcr_regs pdcr_asserts #(.HALF_DUPLEX(HALF_DUPLEX)) chk_u (.pclk, .presetn, .psel,
   .penable, .pwrite, .paddr,
   .pwdata, .prdata, .pready, .pslverr, .xfer_size, .rx_item_done, .tx_item_done,
   .rx_request_active, .tx_request_active, .rx_mem_addr, .tx_mem_addr, .rx_end_flag,
   .rx_buffer_full_flag, .tx_end_flag, .tx_buffer_empty_flag);

/* tb/testbench.sv */
// Self-checking bench for the peripheral DMA channel registers
`timescale 1ns/1ps
`define CHK(g, e) begin compares = compares + 1; if ((g) !== (e)) begin \
   mismatches = mismatches + 1; \
   $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module testbench;
   reg pclk = 1'b0;
   reg presetn = 1'b0;
   reg psel = 1'b0;
   reg penable = 1'b0;
   reg pwrite = 1'b0;
   reg [11:0] paddr = 12'h000;
   reg [31:0] pwdata = 32'h0000_0000;
   reg [1:0] xfer_size = 2'b00;
   wire [31:0] prdata, rxm, txm;
   wire pready, pslverr, rxd, txd, rxa, txa, rxe, rxf, txe, txf;
   wire [31:0] hd_rdata;
   wire hd_rxd, hd_txd, hd_rxa, hd_txa;
   integer mismatches = 0;
   integer compares = 0;
   integer d, s, n;
   reg [31:0] rng = 32'h0000_8777;
   reg [31:0] q, q2, a0, a1;
   reg [35:0] c;
   reg err;
   always #10 pclk = ~pclk;
   pdcr_regs dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .xfer_size(xfer_size), .rx_item_done(rxd), .tx_item_done(txd),
      .rx_request_active(rxa), .tx_request_active(txa), .rx_mem_addr(rxm),
      .tx_mem_addr(txm), .rx_end_flag(rxe), .rx_buffer_full_flag(rxf),
      .tx_end_flag(txe), .tx_buffer_empty_flag(txf));
   pdcr_periph_model model_u (.pclk(pclk), .presetn(presetn), .rx_request_active(rxa),
      .tx_request_active(txa), .rx_item_done(rxd), .tx_item_done(txd));
   // Half duplex instance on the same bus; only its read data is compared
   pdcr_regs #(.HALF_DUPLEX(1)) hd_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(hd_rdata),
      .pready(), .pslverr(), .xfer_size(xfer_size), .rx_item_done(hd_rxd),
      .tx_item_done(hd_txd), .rx_request_active(hd_rxa), .tx_request_active(hd_txa),
      .rx_mem_addr(), .tx_mem_addr(), .rx_end_flag(), .rx_buffer_full_flag(),
      .tx_end_flag(), .tx_buffer_empty_flag());
   pdcr_periph_model hd_model_u (.pclk(pclk), .presetn(presetn), .rx_request_active(hd_rxa),
      .tx_request_active(hd_txa), .rx_item_done(hd_rxd), .tx_item_done(hd_txd));
   function [31:0] xs(input [31:0] x);
      reg [31:0] y;
      begin
         y = x ^ (x << 13);
         y = y ^ (y >> 17);
         xs = y ^ (y << 5);
      end
   endfunction
   function [31:0] stp(input [1:0] z);
      stp = (z == 2'b00) ? 1 : (z == 2'b01) ? 2 : 4;
   endfunction
   // Control write data, then the status expected in full and in half duplex
   function [35:0] ctl(input integer i);
      case (i)
         0: ctl = {12'h001, 12'h001, 12'h001};
         1: ctl = {12'h100, 12'h101, 12'h101};
         2: ctl = {12'h000, 12'h101, 12'h101};
         3: ctl = {12'h003, 12'h100, 12'h000};
         4: ctl = {12'h200, 12'h000, 12'h000};
         5: ctl = {12'h001, 12'h001, 12'h001};
         6: ctl = {12'h200, 12'h001, 12'h000};
         7: ctl = {12'h100, 12'h101, 12'h100};
         8: ctl = {12'h001, 12'h101, 12'h001};
         9: ctl = {12'h202, 12'h000, 12'h000};
         default: ctl = {12'h001, 12'h000, 12'h000};
      endcase
   endfunction
   task apb(input w, input [11:0] a, input [31:0] dt);
      integer k;
      begin
         @(posedge pclk);
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= dt;
         @(posedge pclk);
         penable <= 1'b1;
         k = 0;
         @(posedge pclk);
         while (pready !== 1'b1 && k < 20)
         begin
            @(posedge pclk);
            k = k + 1;
         end
         if (k >= 20)
            mismatches = mismatches + 1;
         q = prdata;
         q2 = hd_rdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   task summarize;
      begin
         $display("compares %0d mismatches %0d", compares, mismatches);
         if (mismatches == 0 && compares > 0)
            $display("TEST PASSED");
         else
            $display("TEST FAILED");
         $finish;
      end
   endtask
   initial
   begin
      #200_000;
      mismatches = mismatches + 1;
      summarize;
   end
   initial
   begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      for (n = 0; n < 11; n = n + 1)
      begin
         apb(1'b0, 12'h100 + n * 4, 0);
         `CHK(q, 32'h0000_0000)
         `CHK(err, n == 10)
      end
      repeat (4) for (n = 0; n < 8; n = n + 1)
      begin
         rng = xs(rng);
         apb(1'b1, 12'h100 + n * 4, rng);
         apb(1'b0, 12'h100 + n * 4, 0);
         `CHK(q, n[0] ? {16'h0000, rng[15:0]} : rng)
         apb(1'b0, 12'h100 + (n ^ 2) * 4, 0);
         `CHK(q2, n[0] ? {16'h0000, rng[15:0]} : rng)
      end
      for (n = 0; n < 11; n = n + 1)
      begin
         c = ctl(n);
         apb(1'b1, n == 10 ? 12'h124 : 12'h120, {20'h0_0000, c[35:24]});
         apb(1'b0, 12'h124, 0);
         `CHK(q, {20'h0_0000, c[23:12]})
         `CHK(q2, {20'h0_0000, c[11:0]})
      end
      for (d = 0; d < 2; d = d + 1) for (s = 0; s < 3; s = s + 1)
      begin
         rng = xs(rng);
         a0 = rng;
         rng = xs(rng);
         a1 = rng;
         xfer_size <= s[1:0];
         apb(1'b1, 12'h100 + d * 8, a0);
         apb(1'b1, 12'h104 + d * 8, 3);
         apb(1'b1, 12'h110 + d * 8, a1);
         apb(1'b1, 12'h114 + d * 8, 2);
         repeat (2) @(posedge pclk);
         `CHK(d ? txe : rxe, 1'b0)
         apb(1'b1, 12'h120, d ? 32'h0000_0100 : 32'h0000_0001);
         n = 0;
         while ((d ? txf : rxf) !== 1'b1 && n < 300)
         begin
            @(posedge pclk);
            n = n + 1;
         end
         `CHK(d ? txf : rxf, 1'b1)
         apb(1'b1, 12'h120, d ? 32'h0000_0200 : 32'h0000_0002);
         `CHK(d ? txe : rxe, 1'b1)
         `CHK(d ? txa : rxa, 1'b0)
         `CHK(d ? txm : rxm, a1 + 2 * stp(s))
         apb(1'b0, 12'h104 + d * 8, 0);
         `CHK(q, 32'h0000_0000)
         apb(1'b0, 12'h100 + d * 8, 0);
         `CHK(q, a1 + 2 * stp(s))
         apb(1'b0, 12'h108 - d * 8, 0);
         `CHK(q2, a1 + 2 * stp(s))
         apb(1'b0, 12'h114 + d * 8, 0);
         `CHK(q, 32'h0000_0000)
      end
      summarize;
   end
endmodule // testbench
